// file: rtl/ssd_pkg.sv
// Package for the slot select and address decode block
package ssd_pkg;
	localparam logic [15:0] ADDR_AUX_READ_STATUS = 16'hc013;
	localparam logic [15:0] ADDR_AUX_WRITE_STATUS = 16'hc014;
	localparam logic [15:0] ADDR_ALT_ZP_STATUS = 16'hc016;
	localparam logic [15:0] ADDR_SLOT_SOURCE_SELECT = 16'hc02d;
	localparam logic [15:0] ADDR_MAIN_READ_SELECT = 16'hc002;
	localparam logic [15:0] ADDR_AUX_READ_SELECT = 16'hc003;
	localparam logic [15:0] ADDR_MAIN_WRITE_SELECT = 16'hc004;
	localparam logic [15:0] ADDR_AUX_WRITE_SELECT = 16'hc005;
	localparam logic [15:0] ADDR_MAIN_ZP_SELECT = 16'hc008;
	localparam logic [15:0] ADDR_ALT_ZP_SELECT = 16'hc009;
	localparam logic [11:0] IO_PAGE_HI = 12'hc08;
	localparam logic [7:0] IO_BLOCK_HI = 8'hc0;
	localparam logic [3:0] ROM_PAGE_HI = 4'hc;
	localparam logic [15:0] EXP_ROM_FIRST = 16'hc800;
	localparam logic [15:0] EXP_ROM_LAST = 16'hcffe;
	localparam logic [7:0] SLOT_SELECT_RESET = 8'h00;
	localparam int STATUS_BIT = 7;
	localparam logic [7:0] ALWAYS_IO_SLOTS = 8'h18;
	localparam logic [7:0] ROM_SWITCHED_SLOTS = 8'hf6;
	localparam logic [7:0] IO_SWITCHED_SLOTS = 8'he6;
	localparam logic [7:0] STATUS_ZERO = 8'h00;
endpackage

// file: rtl/ssd_slot_decode.sv
// Slot select register, auxiliary memory switches and slot decode
//
// Operation
// - Aux read status bit 7 reports read bank
// - Aux write status bit 7 reports write bank
// - Alt zero page status bit 7 reports bank
// - Switches act only on writes
// - Slot select register, software read-modify-writes it
// - Bit 7 picks built-in or card slot 7
// - Bit 6 picks built-in or card slot 6
// - Bit 5 picks built-in or card slot 5
// - Bit 4 enables only slot 4 ROM
// - Bit 2 picks built-in or card slot 2
// - Bit 1 picks built-in or card slot 1
// - Slots 3 and 4 I/O always enabled
// - Built-in or card per slot, never both
// - Sixteen I/O addresses per slot from C090
// - I/O select low over slot's sixteen addresses
// - ROM select low over slot's page
// - Expansion strobe low for C800 through CFFE
// - C003 aux read, C002 main read
// - C005 aux write, C004 main write
// - C009 alt zero page, C008 main
`timescale 1ns/1ns
`default_nettype none
module ssd_slot_decode
	import ssd_pkg::*;
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// Processor bus, one cycle per access
	input wire logic cpu_valid,
	input wire logic cpu_write,
	input wire logic [15:0] cpu_addr,
	input wire logic [7:0] cpu_wdata,
	// Register read answer
	output logic [7:0] cpu_rdata,
	output logic cpu_rvalid,
	// Slot selects, bit n for slot n, bit 0 unused
	output logic [7:0] slot_io_select_n,
	output logic [7:0] slot_rom_select_n,
	output logic expansion_rom_strobe_n,
	// Built-in device selects, bit n for slot n
	output logic [7:0] builtin_io_select,
	output logic [7:0] builtin_rom_select,
	// Memory switch state
	output logic aux_read_select,
	output logic aux_write_select,
	output logic alt_stack_zero_page
);

	typedef struct packed {
		logic [7:0] slot_sel;
		logic aux_rd;
		logic aux_wr;
		logic alt_zp;
		logic [7:0] rdata;
		logic rvalid;
		logic [7:0] io_n;
		logic [7:0] rom_n;
		logic strobe_n;
		logic [7:0] bi_io;
		logic [7:0] bi_rom;
	} ssd_state_t;

	ssd_state_t st_q;
	ssd_state_t st_d;

	// Status byte with only the top bit carrying state
	function automatic logic [7:0] status_byte(input logic flag);
		logic [7:0] b;
		b = STATUS_ZERO;
		b[STATUS_BIT] = flag;
		return b;
	endfunction

	// One-hot slot number from an address nibble
	function automatic logic [7:0] slot_hot(input logic [3:0] n);
		logic [7:0] h;
		h = 8'h00;
		if (n[3] == 1'b0) begin
			h[n[2:0]] = 1'b1;
		end
		return h;
	endfunction

	logic [7:0] io_hit;
	logic [7:0] rom_hit;
	logic [7:0] card_io_en;
	logic [7:0] card_rom_en;
	logic exp_hit;

	always_comb begin
		st_d = st_q;
		st_d.rvalid = 1'b0;
		// Slot n I/O at C080 + n*16
		io_hit = 8'h00;
		if (cpu_valid && cpu_addr[15:8] == IO_BLOCK_HI && cpu_addr[7] && cpu_addr[15:4] != IO_PAGE_HI) begin
			io_hit = slot_hot({1'b0, cpu_addr[6:4]});
		end
		rom_hit = 8'h00;
		if (cpu_valid && cpu_addr[15:12] == ROM_PAGE_HI && cpu_addr[11] == 1'b0) begin
			rom_hit = slot_hot(cpu_addr[11:8]);
		end
		rom_hit[0] = 1'b0;
		// CFFF gets no strobe; each card decodes it itself to drop its ROM
		exp_hit = cpu_valid && cpu_addr >= EXP_ROM_FIRST && cpu_addr <= EXP_ROM_LAST;
		// Reserved bits 3 and 0 are masked out of every enable
		card_rom_en = st_q.slot_sel & ROM_SWITCHED_SLOTS;
		// Slot 3 page has no select bit and always belongs to the card
		card_rom_en[3] = 1'b1;
		card_io_en = (st_q.slot_sel & IO_SWITCHED_SLOTS) | ALWAYS_IO_SLOTS;
		st_d.io_n = ~(io_hit & card_io_en);
		st_d.rom_n = ~(rom_hit & card_rom_en);
		st_d.strobe_n = ~exp_hit;
		st_d.bi_io = io_hit & ~card_io_en;
		st_d.bi_rom = rom_hit & ~card_rom_en;
		if (cpu_valid && cpu_write) begin
			// Memory switches take writes only; reads belong to the keyboard
			case (cpu_addr)
				ADDR_MAIN_READ_SELECT: st_d.aux_rd = 1'b0;
				ADDR_AUX_READ_SELECT: st_d.aux_rd = 1'b1;
				ADDR_MAIN_WRITE_SELECT: st_d.aux_wr = 1'b0;
				ADDR_AUX_WRITE_SELECT: st_d.aux_wr = 1'b1;
				ADDR_MAIN_ZP_SELECT: st_d.alt_zp = 1'b0;
				ADDR_ALT_ZP_SELECT: st_d.alt_zp = 1'b1;
				ADDR_SLOT_SOURCE_SELECT: st_d.slot_sel = cpu_wdata;
				default: st_d.slot_sel = st_q.slot_sel;
			endcase
		end
		// Only mapped registers answer, so a stray read never looks like data
		if (cpu_valid && !cpu_write) begin
			st_d.rvalid = 1'b1;
			case (cpu_addr)
				ADDR_AUX_READ_STATUS: st_d.rdata = status_byte(st_q.aux_rd);
				ADDR_AUX_WRITE_STATUS: st_d.rdata = status_byte(st_q.aux_wr);
				ADDR_ALT_ZP_STATUS: st_d.rdata = status_byte(st_q.alt_zp);
				ADDR_SLOT_SOURCE_SELECT: st_d.rdata = st_q.slot_sel;
				default: begin
					st_d.rdata = STATUS_ZERO;
					st_d.rvalid = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			st_q <= '{slot_sel: SLOT_SELECT_RESET, aux_rd: 1'b0, aux_wr: 1'b0, alt_zp: 1'b0,
				rdata: 8'h00, rvalid: 1'b0, io_n: 8'hff, rom_n: 8'hff, strobe_n: 1'b1,
				bi_io: 8'h00, bi_rom: 8'h00};
		end else begin
			st_q <= st_d;
		end
	end

	assign cpu_rdata = st_q.rdata;
	assign cpu_rvalid = st_q.rvalid;
	assign slot_io_select_n = st_q.io_n;
	assign slot_rom_select_n = st_q.rom_n;
	assign expansion_rom_strobe_n = st_q.strobe_n;
	assign builtin_io_select = st_q.bi_io;
	assign builtin_rom_select = st_q.bi_rom;
	assign aux_read_select = st_q.aux_rd;
	assign aux_write_select = st_q.aux_wr;
	assign alt_stack_zero_page = st_q.alt_zp;

	////////////////////////////////////////////////////////////////////////////////
	// Checks

	// Status reads, switch writes, slot select readback, sample slot selects and strobe range
	aux_read_status_a: assert property (@(posedge core_clk) disable iff (rst)
		cpu_valid && !cpu_write && cpu_addr == ADDR_AUX_READ_STATUS
		|=> cpu_rvalid && cpu_rdata == {$past(aux_read_select), 7'h00})
		else $error("aux read status wrong");
	aux_write_status_a: assert property (@(posedge core_clk) disable iff (rst)
		cpu_valid && !cpu_write && cpu_addr == ADDR_AUX_WRITE_STATUS
		|=> cpu_rdata == {$past(aux_write_select), 7'h00})
		else $error("aux write status wrong");
	alt_zp_status_a: assert property (@(posedge core_clk) disable iff (rst)
		cpu_valid && !cpu_write && cpu_addr == ADDR_ALT_ZP_STATUS
		|=> cpu_rdata == {$past(alt_stack_zero_page), 7'h00})
		else $error("alt zero page status wrong");
	switch_read_a: assert property (@(posedge core_clk) disable iff (rst)
		cpu_valid && !cpu_write |=> $stable(aux_read_select) && $stable(alt_stack_zero_page))
		else $error("switch moved on a read");
	read_sel_set_a: assert property (@(posedge core_clk) disable iff (rst)
		cpu_valid && cpu_write && cpu_addr == ADDR_AUX_READ_SELECT ##1 !(cpu_valid && cpu_write)
		|=> aux_read_select)
		else $error("aux read select not held");
	write_sel_a: assert property (@(posedge core_clk) disable iff (rst)
		cpu_valid && cpu_write && cpu_addr == ADDR_MAIN_WRITE_SELECT |=> !aux_write_select)
		else $error("main write select failed");
	zp_sel_a: assert property (@(posedge core_clk) disable iff (rst)
		cpu_valid && cpu_write && cpu_addr == ADDR_ALT_ZP_SELECT |=> alt_stack_zero_page)
		else $error("alt zero page select failed");
	slot_sel_rmw_a: assert property (@(posedge core_clk) disable iff (rst)
		cpu_valid && cpu_write && cpu_addr == ADDR_SLOT_SOURCE_SELECT ##1
		cpu_valid && !cpu_write && cpu_addr == ADDR_SLOT_SOURCE_SELECT
		|=> cpu_rdata == $past(cpu_wdata, 2))
		else $error("slot select readback wrong");
	io_slot7_a: assert property (@(posedge core_clk) disable iff (rst)
		cpu_valid && cpu_addr[15:4] == 12'hc0f |=> slot_io_select_n[7] == !$past(st_q.slot_sel[7]))
		else $error("slot 7 io select wrong");
	io_slot3_a: assert property (@(posedge core_clk) disable iff (rst)
		cpu_valid && cpu_addr[15:4] == 12'hc0b |=> !slot_io_select_n[3])
		else $error("slot 3 io not always enabled");
	never_both_a: assert property (@(posedge core_clk) disable iff (rst)
		((~slot_io_select_n) & builtin_io_select) == 8'h00 && ((~slot_rom_select_n) & builtin_rom_select) == 8'h00)
		else $error("card and built-in both selected");
	rom_slot4_a: assert property (@(posedge core_clk) disable iff (rst)
		cpu_valid && cpu_addr[15:8] == 8'hc4 |=> slot_rom_select_n[4] == !st_q.slot_sel[4])
		else $error("slot 4 rom select wrong");
	strobe_range_a: assert property (@(posedge core_clk) disable iff (rst)
		cpu_valid |=> expansion_rom_strobe_n == !($past(cpu_addr) >= 16'hc800 && $past(cpu_addr) <= 16'hcffe))
		else $error("expansion strobe wrong");
	one_select_a: assert property (@(posedge core_clk) disable iff (rst)
		$onehot0(~slot_io_select_n))
		else $error("more than one io select");

	// Per-slot I/O selects
	io_slot6_a: assert property (@(posedge core_clk) disable iff (rst)
		cpu_valid && cpu_addr[15:4] == 12'hc0e |=> slot_io_select_n[6] == !$past(st_q.slot_sel[6]))
		else $error("slot 6 io select wrong");
	io_slot5_a: assert property (@(posedge core_clk) disable iff (rst)
		cpu_valid && cpu_addr[15:4] == 12'hc0d |=> slot_io_select_n[5] == !$past(st_q.slot_sel[5]))
		else $error("slot 5 io select wrong");
	io_slot2_a: assert property (@(posedge core_clk) disable iff (rst)
		cpu_valid && cpu_addr[15:4] == 12'hc0a |=> slot_io_select_n[2] == !$past(st_q.slot_sel[2]))
		else $error("slot 2 io select wrong");
	io_slot1_a: assert property (@(posedge core_clk) disable iff (rst)
		cpu_valid && cpu_addr[15:4] == 12'hc09 |=> slot_io_select_n[1] == !$past(st_q.slot_sel[1]))
		else $error("slot 1 io select wrong");
	io_slot4_a: assert property (@(posedge core_clk) disable iff (rst)
		cpu_valid && cpu_addr[15:4] == 12'hc0c |=> !slot_io_select_n[4])
		else $error("slot 4 io not always enabled");
	io_span_a: assert property (@(posedge core_clk) disable iff (rst)
		!(&slot_io_select_n) |-> $past(cpu_valid) && $past(cpu_addr[15:4]) >= 12'hc09 && $past(cpu_addr[15:4]) <= 12'hc0f)
		else $error("io select outside slot space");
	io_slot_match_a: assert property (@(posedge core_clk) disable iff (rst)
		!(&slot_io_select_n) |-> ~slot_io_select_n == (8'h01 << $past(cpu_addr[6:4])))
		else $error("io select on wrong slot");
	io_pulse_a: assert property (@(posedge core_clk) disable iff (rst)
		!cpu_valid |=> &slot_io_select_n && &slot_rom_select_n && expansion_rom_strobe_n && !cpu_rvalid)
		else $error("select held without access");
	io_served_a: assert property (@(posedge core_clk) disable iff (rst)
		cpu_valid && cpu_addr[15:4] >= 12'hc09 && cpu_addr[15:4] <= 12'hc0f
		|=> $onehot(builtin_io_select | ~slot_io_select_n))
		else $error("io access not served once");

	// Per-slot ROM selects and built-in selects
	rom_slot7_a: assert property (@(posedge core_clk) disable iff (rst)
		cpu_valid && cpu_addr[15:8] == 8'hc7 |=> slot_rom_select_n[7] == !$past(st_q.slot_sel[7]))
		else $error("slot 7 rom select wrong");
	rom_slot6_a: assert property (@(posedge core_clk) disable iff (rst)
		cpu_valid && cpu_addr[15:8] == 8'hc6 |=> slot_rom_select_n[6] == !$past(st_q.slot_sel[6]))
		else $error("slot 6 rom select wrong");
	rom_slot5_a: assert property (@(posedge core_clk) disable iff (rst)
		cpu_valid && cpu_addr[15:8] == 8'hc5 |=> slot_rom_select_n[5] == !$past(st_q.slot_sel[5]))
		else $error("slot 5 rom select wrong");
	rom_slot2_a: assert property (@(posedge core_clk) disable iff (rst)
		cpu_valid && cpu_addr[15:8] == 8'hc2 |=> slot_rom_select_n[2] == !$past(st_q.slot_sel[2]))
		else $error("slot 2 rom select wrong");
	rom_slot1_a: assert property (@(posedge core_clk) disable iff (rst)
		cpu_valid && cpu_addr[15:8] == 8'hc1 |=> slot_rom_select_n[1] == !$past(st_q.slot_sel[1]))
		else $error("slot 1 rom select wrong");
	rom_slot3_a: assert property (@(posedge core_clk) disable iff (rst)
		cpu_valid && cpu_addr[15:8] == 8'hc3 |=> !slot_rom_select_n[3])
		else $error("slot 3 rom select wrong");
	rom_page_match_a: assert property (@(posedge core_clk) disable iff (rst)
		!(&slot_rom_select_n) |-> $past(cpu_valid) && $past(cpu_addr[15:11]) == 5'h18
		&& ~slot_rom_select_n == (8'h01 << $past(cpu_addr[10:8])))
		else $error("rom select on wrong page");
	one_rom_select_a: assert property (@(posedge core_clk) disable iff (rst)
		$onehot0(~slot_rom_select_n))
		else $error("more than one rom select");
	rom_served_a: assert property (@(posedge core_clk) disable iff (rst)
		cpu_valid && cpu_addr[15:8] >= 8'hc1 && cpu_addr[15:8] <= 8'hc7
		|=> $onehot(builtin_rom_select | ~slot_rom_select_n))
		else $error("rom access not served once");
	builtin_pulse_a: assert property (@(posedge core_clk) disable iff (rst)
		!cpu_valid |=> builtin_io_select == 8'h00 && builtin_rom_select == 8'h00)
		else $error("built-in select without access");
	reserved_bits_a: assert property (@(posedge core_clk) disable iff (rst)
		slot_io_select_n[0] && slot_rom_select_n[0] && !builtin_io_select[0] && !builtin_rom_select[0]
		&& !builtin_io_select[3] && !builtin_rom_select[3])
		else $error("reserved slot bit decoded");

	// Expansion strobe
	strobe_alone_a: assert property (@(posedge core_clk) disable iff (rst)
		!expansion_rom_strobe_n |-> &slot_io_select_n && &slot_rom_select_n)
		else $error("strobe with a slot select");
	strobe_cfff_a: assert property (@(posedge core_clk) disable iff (rst)
		cpu_valid && cpu_addr == 16'hcfff |=> expansion_rom_strobe_n)
		else $error("strobe on disable address");

	// Switch state and register answers
	read_sel_clr_a: assert property (@(posedge core_clk) disable iff (rst)
		cpu_valid && cpu_write && cpu_addr == ADDR_MAIN_READ_SELECT |=> !aux_read_select)
		else $error("main read select failed");
	write_sel_set_a: assert property (@(posedge core_clk) disable iff (rst)
		cpu_valid && cpu_write && cpu_addr == ADDR_AUX_WRITE_SELECT |=> aux_write_select)
		else $error("aux write select failed");
	zp_sel_clr_a: assert property (@(posedge core_clk) disable iff (rst)
		cpu_valid && cpu_write && cpu_addr == ADDR_MAIN_ZP_SELECT |=> !alt_stack_zero_page)
		else $error("main zero page select failed");
	write_sw_read_a: assert property (@(posedge core_clk) disable iff (rst)
		cpu_valid && !cpu_write |=> $stable(aux_write_select))
		else $error("write switch moved on a read");
	switch_hold_a: assert property (@(posedge core_clk) disable iff (rst)
		!(cpu_valid && cpu_write)
		|=> $stable(aux_read_select) && $stable(aux_write_select) && $stable(alt_stack_zero_page))
		else $error("switch moved without a write");
	slot_sel_write_a: assert property (@(posedge core_clk) disable iff (rst)
		cpu_valid && cpu_write && cpu_addr == ADDR_SLOT_SOURCE_SELECT |=> st_q.slot_sel == $past(cpu_wdata))
		else $error("slot select write lost");
	slot_sel_hold_a: assert property (@(posedge core_clk) disable iff (rst)
		!(cpu_valid && cpu_write && cpu_addr == ADDR_SLOT_SOURCE_SELECT) |=> $stable(st_q.slot_sel))
		else $error("slot select changed unasked");
	status_low_zero_a: assert property (@(posedge core_clk) disable iff (rst)
		cpu_rvalid && $past(cpu_addr) != ADDR_SLOT_SOURCE_SELECT |-> cpu_rdata[6:0] == 7'h00)
		else $error("status low bits not zero");
	rvalid_read_a: assert property (@(posedge core_clk) disable iff (rst)
		cpu_rvalid |-> $past(cpu_valid) && !$past(cpu_write))
		else $error("read answer without a read");
	unmapped_read_a: assert property (@(posedge core_clk) disable iff (rst)
		cpu_valid && !cpu_write && cpu_addr != ADDR_AUX_READ_STATUS && cpu_addr != ADDR_AUX_WRITE_STATUS
		&& cpu_addr != ADDR_ALT_ZP_STATUS && cpu_addr != ADDR_SLOT_SOURCE_SELECT |=> !cpu_rvalid)
		else $error("unmapped read answered");
	status_write_a: assert property (@(posedge core_clk) disable iff (rst)
		cpu_valid && cpu_write |=> !cpu_rvalid)
		else $error("write gave a read answer");

	io_card_c: cover property (@(posedge core_clk) !slot_io_select_n[6]);
	rom_card_c: cover property (@(posedge core_clk) !slot_rom_select_n[5] ##1 !expansion_rom_strobe_n);
	builtin_c: cover property (@(posedge core_clk) builtin_rom_select[1]);
	exp_card_c: cover property (@(posedge core_clk) !slot_rom_select_n[1] ##2 !expansion_rom_strobe_n);
	status_set_c: cover property (@(posedge core_clk) cpu_rvalid && cpu_rdata[7]);

endmodule // ssd_slot_decode
`default_nettype wire

// file: tb/slot_select_decode_tb_top.sv
// Testbench for the slot select and address decode block
`timescale 1ns/1ns
`default_nettype none
module slot_select_decode_tb_top import ssd_pkg::*; ;
	typedef struct packed {logic w; logic [15:0] a; logic [7:0] d, io, rom; logic st, rv;} ssd_row_t;
	logic core_clk, rst, cpu_valid, cpu_write, cpu_rvalid, strb_n, ars, aws, azp, en1, en2;
	logic [15:0] cpu_addr;
	logic [7:0] cpu_wdata, cpu_rdata, io_n, rom_n, b_io, b_rom;
	int n_mismatch = 0;
	int n_compared = 0;
	// Access, data (write data or expected read data), I/O and ROM selects, strobe, read answer
	ssd_row_t rows [27] = '{
		'{1'h0,16'hc0e3,8'h00,8'hff,8'hff,1'h1,1'h0},
		'{1'h0,16'hc0c5,8'h00,8'hef,8'hff,1'h1,1'h0},
		'{1'h0,16'hc0b0,8'h00,8'hf7,8'hff,1'h1,1'h0},
		'{1'h0,16'hc300,8'h00,8'hff,8'hf7,1'h1,1'h0},
		'{1'h0,16'hc400,8'h00,8'hff,8'hff,1'h1,1'h0},
		'{1'h0,16'hc800,8'h00,8'hff,8'hff,1'h0,1'h0},
		'{1'h0,16'hcffe,8'h00,8'hff,8'hff,1'h0,1'h0},
		'{1'h0,16'hcfff,8'h00,8'hff,8'hff,1'h1,1'h0},
		'{1'h1,16'hc02d,8'hff,8'hff,8'hff,1'h1,1'h0},
		'{1'h0,16'hc090,8'h00,8'hfd,8'hff,1'h1,1'h0},
		'{1'h0,16'hc0a0,8'h00,8'hfb,8'hff,1'h1,1'h0},
		'{1'h0,16'hc0d0,8'h00,8'hdf,8'hff,1'h1,1'h0},
		'{1'h0,16'hc0ff,8'h00,8'h7f,8'hff,1'h1,1'h0},
		'{1'h0,16'hc100,8'h00,8'hff,8'hfd,1'h1,1'h0},
		'{1'h0,16'hc4ff,8'h00,8'hff,8'hef,1'h1,1'h0},
		'{1'h0,16'hc7ff,8'h00,8'hff,8'h7f,1'h1,1'h0},
		'{1'h0,16'hc02d,8'hff,8'hff,8'hff,1'h1,1'h1},
		'{1'h1,16'hc02d,8'h09,8'hff,8'hff,1'h1,1'h0},
		'{1'h0,16'hc0ef,8'h00,8'hff,8'hff,1'h1,1'h0},
		'{1'h0,16'hc02d,8'h09,8'hff,8'hff,1'h1,1'h1},
		'{1'h1,16'hc003,8'h00,8'hff,8'hff,1'h1,1'h0},
		'{1'h0,16'hc013,8'h80,8'hff,8'hff,1'h1,1'h1},
		'{1'h1,16'hc005,8'h00,8'hff,8'hff,1'h1,1'h0},
		'{1'h0,16'hc004,8'h00,8'hff,8'hff,1'h1,1'h0},
		'{1'h0,16'hc014,8'h80,8'hff,8'hff,1'h1,1'h1},
		'{1'h1,16'hc009,8'h00,8'hff,8'hff,1'h1,1'h0},
		'{1'h0,16'hc016,8'h80,8'hff,8'hff,1'h1,1'h1}
	};
	ssd_slot_decode i_ssd_slot_decode (.core_clk(core_clk), .rst(rst), .cpu_valid(cpu_valid),
		.cpu_write(cpu_write), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata),
		.cpu_rvalid(cpu_rvalid), .slot_io_select_n(io_n), .slot_rom_select_n(rom_n),
		.expansion_rom_strobe_n(strb_n), .builtin_io_select(b_io), .builtin_rom_select(b_rom),
		.aux_read_select(ars), .aux_write_select(aws), .alt_stack_zero_page(azp));
	ssd_card_model i_card_slot1 (.core_clk(core_clk), .rst(rst), .cpu_valid(cpu_valid), .cpu_addr(cpu_addr),
		.rom_select_n(rom_n[1]), .expansion_rom_strobe_n(strb_n), .rom_enable(en1));
	ssd_card_model i_card_slot2 (.core_clk(core_clk), .rst(rst), .cpu_valid(cpu_valid), .cpu_addr(cpu_addr),
		.rom_select_n(rom_n[2]), .expansion_rom_strobe_n(strb_n), .rom_enable(en2));
	////////////////////////////////////////////////////////////////////////////////
	task automatic close_out;
		$display("compared %0d mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// One access, then settle just after the edge that answers it
	task automatic acc(input logic w, input logic [15:0] a, input logic [7:0] d);
		@(posedge core_clk);
		cpu_valid <= 1'h1;
		cpu_write <= w;
		cpu_addr <= a;
		cpu_wdata <= d;
		@(posedge core_clk);
		cpu_valid <= 1'h0;
		#1;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		core_clk = 1'h0;
		forever #5 core_clk = ~core_clk;
	end
	initial begin
		repeat (5000) @(posedge core_clk);
		n_mismatch++;
		close_out;
	end
	initial begin
		rst = 1'h1;
		cpu_valid = 1'h0;
		cpu_write = 1'h0;
		cpu_addr = 16'h0000;
		cpu_wdata = 8'h00;
		repeat (8) @(posedge core_clk);
		rst <= 1'h0;
		#1;
		cmp(io_n & rom_n, 8'hff);
		cmp(8'({ars, aws, azp, strb_n}), 8'h01);
		foreach (rows[i]) begin
			acc(rows[i].w, rows[i].a, rows[i].d);
			cmp(io_n, rows[i].io);
			cmp(rom_n, rows[i].rom);
			cmp(8'(strb_n), 8'(rows[i].st));
			cmp(8'(cpu_rvalid), 8'(rows[i].rv));
			cmp(rows[i].rv ? cpu_rdata : rows[i].d, rows[i].d);
			cmp((~io_n & b_io) | (~rom_n & b_rom), 8'h00);
		end
		cmp(8'({ars, aws, azp}), 8'h07);
		acc(1'h1, 16'hc002, 8'h00);
		cmp(8'({ars, aws, azp}), 8'h03);
		acc(1'h1, 16'hc02d, 8'hff);
		acc(1'h0, 16'hc100, 8'h00);
		acc(1'h0, 16'hc800, 8'h00);
		cmp(8'({en1, en2}), 8'h02);
		acc(1'h0, 16'hcfff, 8'h00);
		acc(1'h0, 16'hc200, 8'h00);
		acc(1'h0, 16'hc800, 8'h00);
		cmp(8'({en1, en2}), 8'h01);
		// Read-modify-write of the slot select register, write and read back to back
		acc(1'h0, 16'hc02d, 8'h00);
		cmp(cpu_rdata, 8'hff);
		@(posedge core_clk);
		cpu_valid <= 1'h1;
		cpu_write <= 1'h1;
		cpu_addr <= 16'hc02d;
		cpu_wdata <= cpu_rdata & 8'hbf;
		@(posedge core_clk);
		cpu_write <= 1'h0;
		@(posedge core_clk);
		cpu_valid <= 1'h0;
		#1;
		cmp(cpu_rdata, 8'hbf);
		acc(1'h0, 16'hc0e0, 8'h00);
		cmp(io_n, 8'hff);
		cmp(b_io, 8'h40);
		// Reset in mid-run returns every switched select to its built-in device; slot 3 and slot 4 I/O stay on the card
		@(posedge core_clk);
		rst <= 1'h1;
		@(posedge core_clk);
		rst <= 1'h0;
		acc(1'h0, 16'hc0f0, 8'h00);
		cmp(io_n, 8'hff);
		cmp(b_io, 8'h80);
		cmp(8'({ars, aws, azp}), 8'h00);
		acc(1'h0, 16'hc500, 8'h00);
		cmp(rom_n, 8'hff);
		cmp(b_rom, 8'h20);
		close_out;
	end
endmodule // slot_select_decode_tb_top
`default_nettype wire

// file: tb/ssd_card_model.sv
// Expansion card model holding its expansion ROM enable flip-flop
`timescale 1ns/1ns
`default_nettype none
module ssd_card_model (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// Processor bus as seen at the slot
	input wire logic cpu_valid,
	input wire logic [15:0] cpu_addr,
	// Slot selects
	input wire logic rom_select_n,
	input wire logic expansion_rom_strobe_n,
	// High while the card drives its expansion ROM
	output logic rom_enable
);
	logic enable_q;
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			enable_q <= 1'h0;
		end else if (cpu_valid && cpu_addr == 16'hcfff) begin
			enable_q <= 1'h0;
		end else if (!rom_select_n) begin
			enable_q <= 1'h1;
		end
	end
	assign rom_enable = enable_q & ~expansion_rom_strobe_n;
endmodule // ssd_card_model
`default_nettype wire
